/* File: hw/fsm_pkg.sv */
// Package for the full-register serial management slave.
// Assumes a 40 MHz system clock sampling the management clock and data pins.
package fsm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // System clock period in ns.
  localparam int unsigned CLK_PERIOD_NS   = 25;
  // Fastest management clock the link may run at, in MHz.
  localparam int unsigned MGMT_CLK_MAX_MHZ = 10;
  // Shortest management clock period in system cycles, rounded down.
  localparam int unsigned MGMT_MIN_CYC    = (1000 / MGMT_CLK_MAX_MHZ) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Frame fields
  // ----------------------------------------------------------------
  // Preamble length in one bits.
  localparam logic [5:0] PRE_LEN      = 6'h20;
  // Read and write opcodes.
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  // Pattern on PHY address bits [2:1] that selects register mode.
  localparam logic [1:0] REG_MODE_SEL = 2'h3;
  // Bit counts for the header and data fields.
  // Header bits after the start zero: start one, opcode, PHY and REG fields.
  localparam logic [4:0] HDR_BITS     = 5'h0D;
  localparam logic [4:0] DATA_BITS    = 5'h10;

  // ----------------------------------------------------------------
  // Register map regions
  // ----------------------------------------------------------------
  localparam logic [7:0] PWR_LO   = 8'h0E;
  localparam logic [7:0] PWR_HI   = 8'h0F;
  localparam logic [7:0] P1C_LO   = 8'h20;
  localparam logic [7:0] P1C_HI   = 8'h24;
  localparam logic [7:0] P1S_LO   = 8'h28;
  localparam logic [7:0] P1S_HI   = 8'h2F;
  localparam logic [7:0] IAC_LO   = 8'h6E;
  localparam logic [7:0] IAC_HI   = 8'h6F;
  localparam logic [7:0] IDAT_LO  = 8'h70;
  localparam logic [7:0] IDAT_HI  = 8'h78;
  localparam logic [7:0] SELFTEST = 8'h88;
  localparam logic [7:0] P4C_LO   = 8'hF0;
  localparam logic [7:0] P4C_HI   = 8'hFE;
  localparam logic [7:0] P4TEST   = 8'hFF;
  // Reserved and factory test spans that are flagged only.
  localparam logic [7:0] RSV0_LO  = 8'h10;
  localparam logic [7:0] RSV0_HI  = 8'h1F;
  localparam logic [7:0] RSV1_LO  = 8'h40;
  localparam logic [7:0] RSV1_HI  = 8'h67;
  localparam logic [7:0] RSV2_LO  = 8'hA0;
  localparam logic [7:0] RSV2_HI  = 8'hBF;

  // Region codes produced by the address decoder.
  typedef enum logic [3:0] {
    FSM_RGN_OTHER,
    FSM_RGN_PWR,
    FSM_RGN_P1_CTRL,
    FSM_RGN_P1_STAT,
    FSM_RGN_IND_CTRL,
    FSM_RGN_IND_DATA,
    FSM_RGN_SELFTEST,
    FSM_RGN_P4_CTRL,
    FSM_RGN_P4_TEST,
    FSM_RGN_RESERVED
  } fsm_region_t;

  // Frame parser states.
  typedef enum logic [2:0] {
    FSM_ST_PRE,
    FSM_ST_HDR,
    FSM_ST_TA,
    FSM_ST_RDATA,
    FSM_ST_WDATA,
    FSM_ST_SKIP
  } fsm_state_t;

  // Register access request to the register file.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    fsm_region_t region;
  } fsm_req_t;

endpackage : fsm_pkg

/* File: hw/fsm_slave.sv */
// Management-frame slave giving full 8-bit register access over clock/data pins.
// Assumes the register file answers a read within the turnaround bit time.
`timescale 1ns/100ps

module fsm_slave
(
  // System clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Management link pins.
  input  wire logic             mgmt_clk,
  input  wire logic             mgmt_data_in,
  output logic                  mgmt_data_out,
  output logic                  mgmt_data_oe,
  // Register file side.
  output fsm_pkg::fsm_req_t     req,
  input  wire logic [7:0]       rdata,
  // Frame seen that was not in register mode or had a bad start.
  output logic                  std_frame
);

  // ----------------------------------------------------------------
  // Address region decode
  // ----------------------------------------------------------------
  // Maps an 8-bit register address to its region; used for reads and writes.
  function automatic fsm_pkg::fsm_region_t region_of(input logic [7:0] a);
    fsm_pkg::fsm_region_t r;
    r = fsm_pkg::FSM_RGN_OTHER;
    if (a >= fsm_pkg::PWR_LO && a <= fsm_pkg::PWR_HI)          r = fsm_pkg::FSM_RGN_PWR;
    else if (a >= fsm_pkg::P1C_LO && a <= fsm_pkg::P1C_HI)     r = fsm_pkg::FSM_RGN_P1_CTRL;
    else if (a >= fsm_pkg::P1S_LO && a <= fsm_pkg::P1S_HI)     r = fsm_pkg::FSM_RGN_P1_STAT;
    else if (a >= fsm_pkg::IAC_LO && a <= fsm_pkg::IAC_HI)     r = fsm_pkg::FSM_RGN_IND_CTRL;
    else if (a >= fsm_pkg::IDAT_LO && a <= fsm_pkg::IDAT_HI)   r = fsm_pkg::FSM_RGN_IND_DATA;
    else if (a == fsm_pkg::SELFTEST)                           r = fsm_pkg::FSM_RGN_SELFTEST;
    else if (a >= fsm_pkg::P4C_LO && a <= fsm_pkg::P4C_HI)     r = fsm_pkg::FSM_RGN_P4_CTRL;
    else if (a == fsm_pkg::P4TEST)                             r = fsm_pkg::FSM_RGN_P4_TEST;
    else if ((a >= fsm_pkg::RSV0_LO && a <= fsm_pkg::RSV0_HI) ||
             (a >= fsm_pkg::RSV1_LO && a <= fsm_pkg::RSV1_HI) ||
             (a >= fsm_pkg::RSV2_LO && a <= fsm_pkg::RSV2_HI))
      r = fsm_pkg::FSM_RGN_RESERVED;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole module state held in one packed struct.
  typedef struct packed {
    logic [1:0]            clk_sync;   // Clock pin synchroniser.
    logic [1:0]            dat_sync;   // Data pin synchroniser.
    logic                  clk_prev;   // Last synchronised clock level.
    fsm_pkg::fsm_state_t   st;         // Parser state.
    logic [5:0]            ones;       // Consecutive preamble ones.
    logic [4:0]            cnt;        // Bits left in current field.
    logic [13:0]           hdr;        // Start, opcode, PHY and REG bits.
    logic [15:0]           sh;         // Data shift register.
    logic                  is_rd;      // Frame is a register read.
    logic                  dout;       // Data pin output value.
    logic                  doe;        // Data pin output enable.
    fsm_pkg::fsm_req_t     req;        // Request to register file.
    logic                  std;        // Standard frame pulse.
  } fsm_state_s_t;

  fsm_state_s_t s_r;    // Registered state.
  fsm_state_s_t s_nxt;  // Next state.

  // Synchronised clock edges and data; the first stage is read only by the second.
  logic rise;
  logic fall;
  logic din;
  assign rise = s_r.clk_sync[1] & ~s_r.clk_prev;
  assign fall = ~s_r.clk_sync[1] & s_r.clk_prev;
  assign din  = s_r.dat_sync[1];

  // Decoded header fields of a completed header.
  logic [1:0] hop;
  logic [4:0] phy;
  logic [4:0] rga;
  logic [7:0] addr8;
  assign hop   = {s_r.hdr[10], s_r.hdr[9]};
  assign phy   = s_r.hdr[8:4];
  assign rga   = {s_r.hdr[3:0], din};
  assign addr8 = {phy[4], phy[3], phy[0], rga};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Samples data on clock rising edges and changes output on falling edges.
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.clk_sync = {s_r.clk_sync[0], mgmt_clk};
    s_nxt.dat_sync = {s_r.dat_sync[0], mgmt_data_in};
    s_nxt.clk_prev = s_r.clk_sync[1];
    s_nxt.req.wr   = 1'b0;
    s_nxt.req.rd   = 1'b0;
    s_nxt.std      = 1'b0;
    if (rise)
    begin
      unique case (s_r.st)
        // Count preamble ones, then look for the zero of the start pattern.
        fsm_pkg::FSM_ST_PRE:
        begin
          if (din)
            s_nxt.ones = (s_r.ones == fsm_pkg::PRE_LEN) ? s_r.ones : s_r.ones + 6'h01;
          else
          begin
            s_nxt.ones = 6'h00;
            if (s_r.ones == fsm_pkg::PRE_LEN)
            begin
              s_nxt.st  = fsm_pkg::FSM_ST_HDR;
              s_nxt.cnt = fsm_pkg::HDR_BITS;
            end
          end
        end
        // Shift in start bit, opcode, PHY and REG fields.
        fsm_pkg::FSM_ST_HDR:
        begin
          s_nxt.hdr = {s_r.hdr[12:0], din};
          s_nxt.cnt = s_r.cnt - 5'h01;
          if (s_r.cnt == 5'h01)
          begin
            s_nxt.st  = fsm_pkg::FSM_ST_TA;
            s_nxt.cnt = 5'h02;
            s_nxt.req.addr   = addr8;
            s_nxt.req.region = region_of(addr8);
            if (!s_r.hdr[11] || phy[2:1] != fsm_pkg::REG_MODE_SEL)
            begin
              // Not register mode or bad start: left to the standard path.
              s_nxt.std   = 1'b1;
              s_nxt.is_rd = 1'b0;
              s_nxt.st    = fsm_pkg::FSM_ST_SKIP;
            end
            else if (hop == fsm_pkg::OP_READ)
            begin
              s_nxt.is_rd  = 1'b1;
              s_nxt.req.rd = 1'b1;
            end
            else if (hop == fsm_pkg::OP_WRITE)
              s_nxt.is_rd = 1'b0;
            else
              s_nxt.st = fsm_pkg::FSM_ST_SKIP;
          end
        end
        // Turnaround: two bit times; write turnaround is 10 from the controller.
        fsm_pkg::FSM_ST_TA:
        begin
          s_nxt.cnt = s_r.cnt - 5'h01;
          if (s_r.cnt == 5'h01)
          begin
            s_nxt.cnt = fsm_pkg::DATA_BITS;
            s_nxt.st  = s_r.is_rd ? fsm_pkg::FSM_ST_RDATA : fsm_pkg::FSM_ST_WDATA;
          end
        end
        // Write data: keep only the low byte.
        fsm_pkg::FSM_ST_WDATA:
        begin
          s_nxt.sh  = {s_r.sh[14:0], din};
          s_nxt.cnt = s_r.cnt - 5'h01;
          if (s_r.cnt == 5'h01)
          begin
            s_nxt.req.wdata = {s_r.sh[6:0], din};
            s_nxt.req.wr    = 1'b1;
            s_nxt.st        = fsm_pkg::FSM_ST_PRE;
          end
        end
        // Read data: counted on rising edges, output moved on falling edges.
        fsm_pkg::FSM_ST_RDATA:
        begin
          s_nxt.cnt = s_r.cnt - 5'h01;
          if (s_r.cnt == 5'h01)
            s_nxt.st = fsm_pkg::FSM_ST_PRE;
        end
        // Leave a foreign frame; its next bit already counts toward the next preamble.
        fsm_pkg::FSM_ST_SKIP:
        begin
          s_nxt.st   = fsm_pkg::FSM_ST_PRE;
          s_nxt.ones = din ? 6'h01 : 6'h00;
        end
      endcase
    end
    // Output drive changes on falling edges.
    if (fall)
    begin
      if (s_r.st == fsm_pkg::FSM_ST_TA && s_r.is_rd && s_r.cnt == 5'h01)
      begin
        s_nxt.doe  = 1'b1;
        s_nxt.dout = 1'b0;
        s_nxt.sh   = {8'h00, rdata};
      end
      else if (s_r.st == fsm_pkg::FSM_ST_RDATA)
      begin
        s_nxt.dout = s_r.sh[15];
        s_nxt.sh   = {s_r.sh[14:0], 1'b0};
      end
      else
      begin
        s_nxt.doe  = 1'b0;
        s_nxt.dout = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Outputs come straight from state flip-flops.
  assign mgmt_data_out = s_r.dout;
  assign mgmt_data_oe  = s_r.doe;
  assign req           = s_r.req;
  assign std_frame     = s_r.std;

endmodule // fsm_slave

/* File: testbench/fsm_slave_props.sv */
// Checker for the register-mode management slave.
// Bound to fsm_slave and sees only its ports.
`timescale 1ns/100ps
module fsm_slave_props
(
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst,
  // Link pins.
  input wire logic              mgmt_clk,
  input wire logic              mgmt_data_in,
  input wire logic              mgmt_data_out,
  input wire logic              mgmt_data_oe,
  // Register side.
  input wire fsm_pkg::fsm_req_t req,
  input wire logic [7:0]        rdata,
  input wire logic              std_frame
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last read request and since the link clock last moved.
  logic [7:0] rd_age_r;
  logic [7:0] idle_r;
  logic       mclk_r;
  // Saturating age counters, so a stuck oe shows up.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_age_r <= 8'hFF;
      idle_r   <= 8'h00;
      mclk_r   <= 1'b0;
    end
    else
    begin
      rd_age_r <= req.rd ? 8'h00 : rd_age_r + {7'h00, rd_age_r != 8'hFF};
      idle_r   <= (mgmt_clk != mclk_r) ? 8'h00 : idle_r + {7'h00, idle_r != 8'hFF};
      mclk_r   <= mgmt_clk;
    end
  end
  excl_req_a: assert property (!(req.rd && req.wr)) else $error("read and write together");
  rd_pulse_a: assert property (req.rd |=> !req.rd) else $error("read pulse too long");
  wr_pulse_a: assert property (req.wr |=> !req.wr) else $error("write pulse too long");
  wr_addr_a: assert property (req.wr |-> $stable(req.addr)) else $error("address moved at write");
  ta_drive_a: assert property (req.rd |-> ##[1:40] mgmt_data_oe) else $error("no turnaround drive");
  ta_zero_a: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_out) else $error("turnaround not zero");
  oe_cause_a: assert property ($rose(mgmt_data_oe) |-> rd_age_r < 8'h28) else $error("drive without read");
  idle_rel_a: assert property (idle_r >= 8'h28 |-> !mgmt_data_oe) else $error("line held in idle");
  std_excl_a: assert property (std_frame |-> !req.wr && !req.rd) else $error("access on plain frame");
  wr_c: cover property (req.wr);
  rd_c: cover property (req.rd);
  std_c: cover property (std_frame);
endmodule // fsm_slave_props

bind fsm_slave fsm_slave_props u_props (.clk(clk), .rst(rst), .mgmt_clk(mgmt_clk), .mgmt_data_in(mgmt_data_in),
  .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe), .req(req), .rdata(rdata), .std_frame(std_frame));

/* File: testbench/fsm_ctl_model.sv */
// Model of the external management controller.
// Assumes a 40 MHz clk; link clock period 200 ns, low between frames.
`timescale 1ns/100ps
module fsm_ctl_model
(
  // Pacing clock.
  input  wire logic clk,
  // Link pins.
  output logic      mdc_o,
  output logic      val_o,
  input  wire logic line_i
);
  // Link clock idles low.
  initial
  begin
    mdc_o = 1'b0;
    val_o = 1'b1;
  end
  // One bit: drive or release (inverted junk), then sample just before the fall.
  task automatic bit_io(input logic b, input logic drv, output logic got);
    val_o = drv ? b : ~val_o;
    repeat (4) @(negedge clk);
    mdc_o = 1'b1;
    repeat (4) @(negedge clk);
    got   = line_i;
    mdc_o = 1'b0;
  endtask
  // Whole frame; rd_o holds the second turnaround bit and the data field.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [16:0] rd_o);
    logic [63:0] bits;
    logic        g;
    bits = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--)
    begin
      bit_io(bits[i], !(op == fsm_pkg::OP_READ && i < 18), g);
      if (i < 17)
        rd_o[i] = g;
    end
    // Released line shows the inverse level; let an edge pass before the next frame drives it.
    val_o = ~val_o;
    @(negedge clk);
  endtask
endmodule // fsm_ctl_model

/* File: testbench/tb_top.sv */
// Self-checking bench for fsm_slave with a controller model.
// Assumes the bench stands in for the register file.
`timescale 1ns/100ps
module tb_top;
  logic                 clk, rst, mdc, ctl_val, line, oe, dout, std_pls;
  fsm_pkg::fsm_req_t    req;
  fsm_pkg::fsm_region_t wr_rgn;
  logic [7:0]           rdata, wr_addr;
  logic [7:0]           mem [256] = '{default: 8'h00};
  int                   errors = 0, checked = 0, n_wr = 0, n_rd = 0, n_std = 0;
  `define CMP(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
  // Wire level: device when enabled, else the controller.
  assign line  = oe ? dout : ctl_val;
  assign rdata = mem[req.addr];
  fsm_slave u_dut (.clk(clk), .rst(rst), .mgmt_clk(mdc), .mgmt_data_in(line), .mgmt_data_out(dout),
                   .mgmt_data_oe(oe), .req(req), .rdata(rdata), .std_frame(std_pls));
  fsm_ctl_model u_ctl (.clk(clk), .mdc_o(mdc), .val_o(ctl_val), .line_i(line));
  // Register file stand-in and event counters.
  always @(posedge clk)
  begin
    if (req.wr)
    begin
      mem[req.addr] <= req.wdata;
      wr_addr       <= req.addr;
      wr_rgn        <= req.region;
      n_wr++;
    end
    n_rd  += req.rd;
    n_std += std_pls;
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Write with junk upper byte, read back, check address, region and data.
  task automatic t_map();
    logic [7:0] ad [11] = '{8'h00, 8'h0E, 8'h24, 8'h28, 8'h6F, 8'h78, 8'h88, 8'hF0, 8'hFE, 8'hFF, 8'h10};
    fsm_pkg::fsm_region_t rg [11] = '{fsm_pkg::FSM_RGN_OTHER, fsm_pkg::FSM_RGN_PWR, fsm_pkg::FSM_RGN_P1_CTRL,
      fsm_pkg::FSM_RGN_P1_STAT, fsm_pkg::FSM_RGN_IND_CTRL, fsm_pkg::FSM_RGN_IND_DATA, fsm_pkg::FSM_RGN_SELFTEST,
      fsm_pkg::FSM_RGN_P4_CTRL, fsm_pkg::FSM_RGN_P4_CTRL, fsm_pkg::FSM_RGN_P4_TEST, fsm_pkg::FSM_RGN_RESERVED};
    logic [16:0] r;
    logic [4:0]  phy;
    int          w0, r0;
    for (int i = 0; i < 11; i++)
    begin
      phy = {ad[i][7:6], fsm_pkg::REG_MODE_SEL, ad[i][5]};
      w0  = n_wr;
      r0  = n_rd;
      u_ctl.frame(fsm_pkg::OP_WRITE, phy, ad[i][4:0], {8'hFF, ad[i] ^ 8'h5A}, r);
      u_ctl.frame(fsm_pkg::OP_READ, phy, ad[i][4:0], 16'h0000, r);
      // Idle gap: the line must be released once the read is over.
      repeat (48) @(negedge clk);
      `CMP(oe, 1'b0)
      `CMP(n_wr - w0, 1)
      `CMP(n_rd - r0, 1)
      `CMP(wr_addr, ad[i])
      `CMP(wr_rgn, rg[i])
      `CMP(r[16], 1'b0)
      `CMP(r[15:8], 8'h00)
      `CMP(r[7:0], ad[i] ^ 8'h5A)
    end
  endtask
  // Plain frame and a bad opcode: no access, plain frame flagged.
  task automatic t_refuse();
    logic [16:0] r;
    int          w0, r0, s0;
    w0 = n_wr;
    r0 = n_rd;
    s0 = n_std;
    u_ctl.frame(fsm_pkg::OP_WRITE, 5'h02, 5'h01, 16'h1234, r);
    u_ctl.frame(2'h3, 5'h06, 5'h01, 16'h1234, r);
    `CMP(n_std - s0, 1)
    `CMP(n_wr - w0, 0)
    `CMP(n_rd - r0, 0)
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_map();
    t_refuse();
    stop_test();
  end
  // Watchdog well beyond the expected 24 frames.
  initial
  begin
    #1000000;
    errors++;
    stop_test();
  end
endmodule // tb_top
